//--- logic/channel_divider.sv
// Purpose: One channel divider working on distribution-path ticks.
// Assumes: tick marks the rising edge of the distribution waveform.
// Notes:   Ratio 1 passes the distribution waveform through.
`timescale 1ns/1ps
module channel_divider
  import clk_out_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic dist_wave,
  input wire logic hold,
  input wire logic [8:0] ratio,
  output logic q
);

  logic [8:0] cnt;
  logic started;
  logic [8:0] half;

  assign half = half_of(ratio);

  // =============================================================
  // Divider with aligned restart
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= 1'b0;
      cnt <= 9'h000;
      started <= 1'b0;
    end else if (ce) begin
      if (hold) begin
        q <= 1'b0; // R7
        cnt <= 9'h000;
        started <= 1'b0;
      end else if (ratio <= 9'h001) begin
        q <= dist_wave;
      end else if (tick) begin
        // Every divider restarts high on the same tick
        if (!started) begin
          q <= 1'b1; // R8
          started <= 1'b1;
          cnt <= 9'h000;
        end else if (cnt == half - 9'h001) begin
          q <= ~q; // R6
          cnt <= 9'h000;
        end else begin
          cnt <= cnt + 9'h001;
        end
      end
    end
  end

endmodule : channel_divider

//--- logic/clk_out_consts.svh
// Purpose: Offsets, field positions, reset values and counts for the
//          clock output control block.
// Assumes: Included by its bare name from the control block, its checker and the bench.
// Notes:   Definitions only.
`ifndef CLK_OUT_CONSTS_SVH
`define CLK_OUT_CONSTS_SVH

// =============================================================
// Register offsets
`define OFS_GLOBAL_CTRL 8'h00
`define OFS_OUTPUT_ENABLE 8'h04
`define OFS_PATH_SELECT 8'h08
`define OFS_PRESCALE 8'h0C
`define OFS_FINAL_CONFIG 8'h10
`define OFS_STATUS 8'h14
`define OFS_CH_RATIO_BASE 8'h20
`define OFS_CH_RATIO_LAST 8'h3C

// =============================================================
// Field positions
`define FLD_ALL_EN 0
`define FLD_FB_ALIGN 1
`define FLD_BYPASS 2
`define FLD_STATUS_SEL_LO 3
`define FLD_STATUS_SEL_HI 4
`define FLD_POWER_DOWN 5
`define FLD_ST_CAL_BUSY 0
`define FLD_ST_CAL_DONE 1
`define FLD_ST_LOCKED 2
`define FLD_ST_ALIGN_HOLD 3
`define FLD_ST_DISABLE_PIN 4
`define FLD_ST_ALIGN_PIN 5

// =============================================================
// Reset values
`define RST_GLOBAL_CTRL 6'h01
`define RST_OUTPUT_ENABLE 8'h00
`define RST_PATH_SELECT 8'h00
`define RST_PRESCALE 4'h2
`define RST_FINAL_CONFIG 8'h00
`define RST_CH_RATIO 9'h002

// =============================================================
// Timing
`define CLK_MHZ 125
`define CAL_TIME_NS 1000
`define CAL_CYCLES ((`CAL_TIME_NS * `CLK_MHZ) / 1000)
`define ALIGN_STAGES 5
`define LOCK_REF_CYCLES 5

`endif

//--- logic/clk_out_pkg.sv
// Purpose: Types shared by the clock output control design files.
// Assumes: Constants live in clk_out_consts.svh.
// Notes:   Half-period helper is used by both design files.
package clk_out_pkg;

  // =============================================================
  // Global control word
  typedef enum logic [1:0] {
    SEL_LOW,
    SEL_LOCK_HIGH,
    SEL_LOCK_LOW,
    SEL_CAL_DONE
  } status_sel_t;

  typedef struct packed {
    logic power_down;
    status_sel_t status_sel;
    logic bypass;
    logic feedback_align;
    logic all_en;
  } global_ctrl_t;

  typedef enum {
    CAL_IDLE,
    CAL_RUN
  } cal_state_t;

  typedef enum {
    LOCK_SEEK,
    LOCK_HELD
  } lock_state_t;

  // =============================================================
  // High length of a waveform of the given ratio
  function automatic logic [8:0] half_of(input logic [8:0] ratio);
    half_of = ratio >> 1;
  endfunction : half_of

endpackage : clk_out_pkg

//--- logic/clock_output_sync_enable.sv
// Purpose: Enable gating, align strobe, calibration trigger and lock
//          indicator for eight distributed clock outputs.
// Assumes: clk is the fast clock; distribution cycles are ticks of it.
// Notes:   Pins pass two flip-flops before any logic reads them.
//
// Function
// [R1] Final word write starts calibration unless aligned
// [R2] Controller keeps reference valid, bypass zero
// [R3] Outputs stay disabled after reset until enabled
// [R4] Enable bits gate off; disable pin forces low
// [R5] Disable pin pulled up; floating means enabled
// [R6] Duty 50%, or ratio/2 on bypassed odd
// [R7] Low align strobe holds divided outputs low
// [R8] Release makes divided outputs rise together
// [R9] Controller holds strobe low over one cycle
// [R10] Outputs low at fifth edge after registering
// [R11] Outputs rise at fifth edge after release
// [R12] Strobe may rise early; alignment still completes
// [R13] Align strobe pulled up; floating runs normally
// [R14] Prescaler bypass ignores align strobe entirely
// [R15] Lock pin to disable pin forces outputs low
// [R16] Power-on loads every register default
// [R17] Lock after five good cycles, drop on large
// [R18] Power-down shows no-lock level on lock pin
// [R19] Strobe and disable pin synchronized twice
// [R20] Calibration end raises a done flag
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "clk_out_consts.svh"
module clock_output_sync_enable
  import clk_out_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic output_disable_pin,
  input wire logic align_n,
  input wire logic ref_tick,
  input wire logic err_below_lock,
  input wire logic err_above_unlock,
  output logic [7:0] clk_out,
  output logic [7:0] out_off,
  output logic lock_indicator_pin,
  output logic cal_done
);

  // =============================================================
  // Register state
  global_ctrl_t ctrl;
  logic [7:0] output_enable_bit;
  logic [7:0] output_path_select;
  logic [3:0] prescale_ratio;
  logic [7:0] final_config_word;
  logic [8:0] channel_ratio [8];

  // Byte address to channel index, used by write and read decode
  function automatic logic [2:0] ch_index(input logic [7:0] a);
    ch_index = a[4:2];
  endfunction : ch_index

  function automatic logic is_ch(input logic [7:0] a);
    is_ch = (a >= `OFS_CH_RATIO_BASE) && (a <= `OFS_CH_RATIO_LAST)
      && (a[1:0] == 2'h0);
  endfunction : is_ch

  logic final_write;
  assign final_write = wr && (addr == `OFS_FINAL_CONFIG);

  // =============================================================
  // Register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= global_ctrl_t'(`RST_GLOBAL_CTRL); // R16
      output_enable_bit <= `RST_OUTPUT_ENABLE; // R3
      output_path_select <= `RST_PATH_SELECT;
      prescale_ratio <= `RST_PRESCALE;
      final_config_word <= `RST_FINAL_CONFIG;
      for (int i = 0; i < 8; i++) begin
        channel_ratio[i] <= `RST_CH_RATIO;
      end
    end else if (ce && wr) begin
      case (addr)
        `OFS_GLOBAL_CTRL: ctrl <= global_ctrl_t'(wdata[5:0]);
        `OFS_OUTPUT_ENABLE: output_enable_bit <= wdata[7:0];
        `OFS_PATH_SELECT: output_path_select <= wdata[7:0];
        `OFS_PRESCALE: prescale_ratio <= wdata[3:0];
        `OFS_FINAL_CONFIG: final_config_word <= wdata[7:0];
        default: begin
          if (is_ch(addr)) begin
            channel_ratio[ch_index(addr)] <= wdata[8:0];
          end
        end
      endcase
    end
  end

  // =============================================================
  // Pin synchronizers
  // Pads carry pull-ups, so an open pin arrives here as a 1
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic ref_prev;
  logic disable_ok;
  logic align_level;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta <= 5'h1F;
      pin_sync <= 5'h1F;
      ref_prev <= 1'b1;
    end else if (ce) begin
      pin_meta <= {err_above_unlock, err_below_lock, ref_tick,
        align_n, output_disable_pin}; // R19
      pin_sync <= pin_meta; // R19
      ref_prev <= pin_sync[2];
    end
  end

  assign disable_ok = pin_sync[0]; // R5
  assign align_level = pin_sync[1]; // R13

  // =============================================================
  // Distribution path ticks from the prescaler
  logic [3:0] pcnt;
  logic [3:0] ratio_eff;
  logic tick;
  logic dist_wave;
  logic byp_wave;

  // Ratios below two are not legal; clamp rather than stall the path
  assign ratio_eff = (prescale_ratio < 4'h2) ? 4'h2 : prescale_ratio;
  assign tick = ctrl.bypass || (pcnt == ratio_eff - 4'h1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pcnt <= 4'h0;
      byp_wave <= 1'b0;
    end else if (ce) begin
      byp_wave <= ~byp_wave;
      if (tick) begin
        pcnt <= 4'h0;
      end else begin
        pcnt <= pcnt + 4'h1;
      end
    end
  end

  // High for floor(ratio/2) of every ratio cycles: 50% on even ratios, 33 to 47% on odd
  assign dist_wave = ctrl.bypass ? byp_wave
    : ({5'h00, pcnt} < half_of({5'h00, ratio_eff})); // R6

  // =============================================================
  // Align strobe pipeline, one stage per distribution cycle
  logic [`ALIGN_STAGES-1:0] align_pipe;
  logic align_hold;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      align_pipe <= '1;
    end else if (ce) begin
      if (ctrl.bypass) begin
        align_pipe <= '1; // R14
      end else if (tick) begin
        // Once a level enters, it walks through regardless of the pin
        align_pipe <= {align_pipe[`ALIGN_STAGES-2:0], align_level}; // R12
      end
    end
  end

  // Fifth tick after the strobe is registered, either way
  assign align_hold = ~align_pipe[`ALIGN_STAGES-1]; // R10 R11

  // =============================================================
  // Channel dividers
  logic [7:0] div_q;

  for (genvar g = 0; g < 8; g++) begin : gen_div
    channel_divider u_div (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .tick(tick),
      .dist_wave(dist_wave),
      .hold(align_hold), // R7 R8
      .ratio(channel_ratio[g]),
      .q(div_q[g])
    );
  end

  // =============================================================
  // Output gating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_out <= 8'h00;
      out_off <= 8'hFF; // R3
    end else if (ce) begin
      for (int i = 0; i < 8; i++) begin
        if (!output_enable_bit[i] || !ctrl.all_en) begin
          clk_out[i] <= 1'b0; // R4
          out_off[i] <= 1'b1; // R4
        end else if (!disable_ok) begin
          clk_out[i] <= 1'b0; // R4 R15
          out_off[i] <= 1'b0;
        end else begin
          // Bypassed paths keep running through an align hold
          clk_out[i] <= output_path_select[i] ? dist_wave : div_q[i]; // R7
          out_off[i] <= 1'b0;
        end
      end
    end
  end

  // =============================================================
  // Oscillator calibration
  cal_state_t cal_state;
  logic [15:0] cal_cnt;
  localparam logic [15:0] CAL_LAST = 16'(`CAL_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_state <= CAL_IDLE;
      cal_cnt <= 16'h0000;
      cal_done <= 1'b0;
    end else if (ce) begin
      // Trusts the controller to keep reference valid and bypass off
      if (final_write && !ctrl.feedback_align) begin
        cal_state <= CAL_RUN; // R1 R2
        cal_cnt <= 16'h0000;
        cal_done <= 1'b0;
      end else begin
        case (cal_state)
          CAL_IDLE: cal_cnt <= 16'h0000;
          CAL_RUN: begin
            if (cal_cnt == CAL_LAST) begin
              cal_state <= CAL_IDLE;
              cal_done <= 1'b1; // R20
            end else begin
              cal_cnt <= cal_cnt + 16'h0001;
            end
          end
          default: cal_state <= CAL_IDLE;
        endcase
      end
    end
  end

  // =============================================================
  // Lock detect on reference cycles
  lock_state_t lock_state;
  logic [2:0] good_cnt;
  logic ref_edge;

  assign ref_edge = pin_sync[2] && !ref_prev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_state <= LOCK_SEEK;
      good_cnt <= 3'h0;
    end else if (ce) begin
      if (ctrl.power_down) begin
        lock_state <= LOCK_SEEK; // R18
        good_cnt <= 3'h0;
      end else if (ref_edge) begin
        case (lock_state)
          LOCK_SEEK: begin
            if (!pin_sync[3]) begin
              good_cnt <= 3'h0;
            end else if (good_cnt == 3'(`LOCK_REF_CYCLES - 1)) begin
              lock_state <= LOCK_HELD; // R17
              good_cnt <= 3'h0;
            end else begin
              good_cnt <= good_cnt + 3'h1;
            end
          end
          LOCK_HELD: begin
            if (pin_sync[4]) begin
              lock_state <= LOCK_SEEK; // R17
            end
          end
          default: lock_state <= LOCK_SEEK;
        endcase
      end
    end
  end

  // With SEL_LOCK_HIGH selected, wiring this pin to the disable pin forces outputs low on unlock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_indicator_pin <= 1'b0;
    end else if (ce) begin
      case (ctrl.status_sel)
        SEL_LOCK_HIGH: lock_indicator_pin <= (lock_state == LOCK_HELD); // R15
        SEL_LOCK_LOW: lock_indicator_pin <= (lock_state != LOCK_HELD); // R18
        SEL_CAL_DONE: lock_indicator_pin <= cal_done;
        default: lock_indicator_pin <= 1'b0;
      endcase
    end
  end

  // =============================================================
  // Register reads, data in the following cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= 32'h0000_0000;
      if (rd) begin
        case (addr)
          `OFS_GLOBAL_CTRL: rdata <= {26'h0, ctrl};
          `OFS_OUTPUT_ENABLE: rdata <= {24'h0, output_enable_bit};
          `OFS_PATH_SELECT: rdata <= {24'h0, output_path_select};
          `OFS_PRESCALE: rdata <= {28'h0, prescale_ratio};
          `OFS_FINAL_CONFIG: rdata <= {24'h0, final_config_word};
          `OFS_STATUS: begin
            rdata[`FLD_ST_CAL_BUSY] <= (cal_state == CAL_RUN);
            rdata[`FLD_ST_CAL_DONE] <= cal_done;
            rdata[`FLD_ST_LOCKED] <= (lock_state == LOCK_HELD);
            rdata[`FLD_ST_ALIGN_HOLD] <= align_hold;
            rdata[`FLD_ST_DISABLE_PIN] <= disable_ok;
            rdata[`FLD_ST_ALIGN_PIN] <= align_level;
          end
          default: begin
            if (is_ch(addr)) begin
              rdata <= {23'h0, channel_ratio[ch_index(addr)]};
            end
          end
        endcase
      end
    end
  end

endmodule : clock_output_sync_enable

//--- tb/clock_output_sync_enable_sva.sv
// Purpose: Port checks for the clock output control block.
// Assumes: Register writes are mirrored here from the port.
// Notes:   Latency bounds carry slack, up to eight cycles on the calibration window.
`timescale 1ns/1ps
`include "clk_out_consts.svh"
module clock_output_sync_enable_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic output_disable_pin,
  input wire logic align_n,
  input wire logic ref_tick,
  input wire logic err_below_lock,
  input wire logic err_above_unlock,
  input wire logic [7:0] clk_out,
  input wire logic [7:0] out_off,
  input wire logic lock_indicator_pin,
  input wire logic cal_done
);
  logic [5:0] g;
  logic [7:0] en;
  logic [7:0] ps;
  logic en_seen;
  logic [1:0] quiet;
  logic [6:0] lo_cnt;
  logic fin;
  assign fin = ce && wr && addr == `OFS_FINAL_CONFIG;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Mirrors of written settings
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      g <= `RST_GLOBAL_CTRL;
      en <= 8'h00;
      ps <= 8'h00;
      en_seen <= 1'b0;
      quiet <= 2'h0;
    end else if (ce && wr) begin
      quiet <= 2'h0;
      if (addr == `OFS_GLOBAL_CTRL) g <= wdata[5:0];
      if (addr == `OFS_OUTPUT_ENABLE) en <= wdata[7:0];
      if (addr == `OFS_OUTPUT_ENABLE) en_seen <= 1'b1;
      if (addr == `OFS_PATH_SELECT) ps <= wdata[7:0];
    end else if (quiet != 2'h3) begin
      quiet <= quiet + 2'h1;
    end
  end

  // Saturating so a long hold never wraps back
  always_ff @(posedge clk) begin
    if (!rst_n || align_n) lo_cnt <= 7'h00;
    else if (lo_cnt != 7'h7F) lo_cnt <= lo_cnt + 7'h01;
  end

  // ==========================================================
  // Properties
  property p_rst_off;
    $rose(rst_n) |-> out_off == 8'hFF && clk_out == 8'h00;
  endproperty
  property p_idle_off;
    !en_seen |-> out_off == 8'hFF;
  endproperty
  property p_gate;
    quiet == 2'h3 |-> out_off == ~(en & {8{g[0]}});
  endproperty
  property p_disable_low;
    !output_disable_pin [*5] |-> (clk_out & ~out_off) == 8'h00;
  endproperty
  property p_cal;
    fin && !g[1] |=> !cal_done [*8] ##[110:125] cal_done;
  endproperty
  property p_cal_keep;
    fin && g[1] && cal_done |=> cal_done [*8];
  endproperty
  property p_pd_high;
    (g[5] && g[4:3] == 2'h1) [*3] |-> !lock_indicator_pin;
  endproperty
  property p_pd_low;
    (g[5] && g[4:3] == 2'h2) [*3] |-> lock_indicator_pin;
  endproperty
  property p_align_hold;
    lo_cnt >= 7'h64 && !g[2] |-> (clk_out & ~ps & ~out_off) == 8'h00;
  endproperty

  a_rst_off: assert property (p_rst_off)
    else $error("outputs not off at reset release");
  a_idle_off: assert property (p_idle_off)
    else $error("output left off state before enable");
  a_gate: assert property (p_gate)
    else $error("off state does not follow enable bits");
  a_disable_low: assert property (p_disable_low)
    else $error("output not low with disable pin low");
  a_cal: assert property (p_cal)
    else $error("calibration done flag timing wrong");
  a_cal_keep: assert property (p_cal_keep)
    else $error("calibration restarted in align mode");
  a_pd_high: assert property (p_pd_high)
    else $error("lock pin not low in power down");
  a_pd_low: assert property (p_pd_low)
    else $error("lock pin not high in power down");
  a_align_hold: assert property (p_align_hold)
    else $error("divided output moved during align hold");

  c_cal: cover property (cal_done);
  c_hold: cover property (lo_cnt >= 7'h64);
  c_lock: cover property (lock_indicator_pin && !g[5]);
endmodule : clock_output_sync_enable_sva

bind clock_output_sync_enable clock_output_sync_enable_sva u_sva (
  .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata),
  .output_disable_pin(output_disable_pin), .align_n(align_n),
  .ref_tick(ref_tick), .err_below_lock(err_below_lock),
  .err_above_unlock(err_above_unlock), .clk_out(clk_out),
  .out_off(out_off), .lock_indicator_pin(lock_indicator_pin),
  .cal_done(cal_done)
);

//--- tb/ref_source.sv
// Purpose: Reference and phase-error source for the lock logic.
// Assumes: Reference runs free at one eighth of clk.
// Notes:   Error flags move on the falling reference edge only.
`timescale 1ns/1ps
module ref_source (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic good,
  input wire logic bad,
  output logic ref_tick,
  output logic err_below_lock,
  output logic err_above_unlock
);
  logic [1:0] div;

  // ==========================================================
  // Reference kept toggling so calibration sees a valid input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div <= 2'h0;
      ref_tick <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        ref_tick <= ~ref_tick;
      end
    end
  end

  // Flags settle away from the sampled rise; known levels from reset on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_below_lock <= 1'b0;
      err_above_unlock <= 1'b0;
    end else if (div == 2'h3 && ref_tick) begin
      err_below_lock <= good;
      err_above_unlock <= bad;
    end
  end
endmodule : ref_source

//--- tb/tb.sv
// Purpose: Bench for the clock output control block.
// Assumes: ce held high; ref_source drives the lock inputs.
// Notes:   Output checks sample on the falling edge.
`timescale 1ns/1ps
`include "clk_out_consts.svh"
module tb;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, odp = 1, align_n = 1;
  logic good = 0, bad = 0, loop_en = 0, lk, rt, eb, ea, cal_done;
  logic [7:0] addr = 8'h00, clk_out, out_off, hi, lo;
  logic [31:0] wdata = 32'h0, rdata;
  logic [2:0] b;
  int n_fail = 0, n_tests = 0, t, h0, h1;
  int pv [4] = '{3, 4, 5, 7};
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
    8'h20, 8'h3C, 8'h18};
  logic [31:0] rv [9] = '{32'h1, 32'h0, 32'h0, 32'h2, 32'h0, 32'h30,
    32'h2, 32'h2, 32'h0};
  // Lock pin looped onto the disable pin on demand
  wire logic odp_w = loop_en ? lk : odp;
  always #4 clk = ~clk;

  clock_output_sync_enable u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .output_disable_pin(odp_w), .align_n(align_n), .ref_tick(rt),
    .err_below_lock(eb), .err_above_unlock(ea), .clk_out(clk_out),
    .out_off(out_off), .lock_indicator_pin(lk), .cal_done(cal_done));
  ref_source u_ref (.clk(clk), .rst_n(rst_n), .good(good), .bad(bad),
    .ref_tick(rt), .err_below_lock(eb), .err_above_unlock(ea));

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic nx(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : nx
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd_chk
  task automatic watch(input int n);
    hi = 8'h00;
    lo = 8'h00;
    repeat (n) begin
      @(negedge clk);
      hi = hi | clk_out;
      lo = lo | ~clk_out;
    end
  endtask : watch
  task automatic duty(input int n);
    h0 = 0;
    h1 = 0;
    repeat (n) begin
      @(negedge clk);
      h0 += clk_out[0];
      h1 += clk_out[1];
    end
  endtask : duty
  // Rise of divided outputs after at least three all-low cycles
  task automatic rise();
    int z;
    bit done;
    z = 0;
    t = 0;
    done = 0;
    repeat (60) if (!done) begin
      @(negedge clk);
      t++;
      b = clk_out[3:1];
      if (b == 3'b000) z++;
      else if (z >= 3) done = 1;
      else z = 0;
    end
  endtask : rise
  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Sequence
  initial begin
    cyc(2);
    rst_n <= 1'b1;
    nx(0);
    chk(out_off, 8'hFF);
    for (int i = 0; i < 9; i++) rd_chk(ra[i], rv[i]);
    wr_reg(`OFS_OUTPUT_ENABLE, 32'h0F);
    nx(3);
    chk(out_off, 8'hF0);
    watch(16);
    chk(hi & lo, 8'h0F);
    wr_reg(`OFS_GLOBAL_CTRL, 32'h0);
    nx(3);
    chk(out_off, 8'hFF);
    wr_reg(`OFS_GLOBAL_CTRL, 32'h1);
    odp <= 1'b0;
    nx(6);
    watch(16);
    chk(hi, 8'h00);
    chk(out_off, 8'hF0);
    @(posedge clk);
    odp <= 1'b1;
    wr_reg(`OFS_PATH_SELECT, 32'h02);
    foreach (pv[i]) begin
      wr_reg(`OFS_PRESCALE, pv[i]);
      cyc(20);
      duty(6 * pv[i]);
      chk(h0, 3 * pv[i]);
      chk(h1, 6 * (pv[i] / 2));
    end
    wr_reg(`OFS_PATH_SELECT, 32'h01);
    wr_reg(`OFS_PRESCALE, 32'h2);
    wr_reg(8'h28, 32'h4);
    align_n <= 1'b0;
    cyc(90);
    watch(20);
    chk(hi & lo, 8'h01);
    @(posedge clk);
    align_n <= 1'b1;
    rise();
    chk(b, 3'b111);
    chk(t >= 10 && t <= 22, 1);
    cyc(20);
    align_n <= 1'b0;
    watch(5);
    chk(hi & lo & 8'h0A, 8'h0A);
    @(posedge clk);
    align_n <= 1'b1;
    rise();
    chk(b, 3'b111);
    chk(t < 40, 1);
    wr_reg(`OFS_GLOBAL_CTRL, 32'h5);
    align_n <= 1'b0;
    cyc(40);
    watch(20);
    chk(hi & lo & 8'h0E, 8'h0E);
    @(posedge clk);
    align_n <= 1'b1;
    wr_reg(`OFS_GLOBAL_CTRL, 32'h1);
    wr_reg(`OFS_FINAL_CONFIG, 32'h5A);
    t = 0;
    while (t < 200 && cal_done !== 1'b1) begin
      @(negedge clk);
      t++;
    end
    chk(t >= 120 && t <= 130, 1);
    rd_chk(`OFS_STATUS, 32'h32);
    wr_reg(`OFS_GLOBAL_CTRL, 32'h3);
    wr_reg(`OFS_FINAL_CONFIG, 32'h5A);
    nx(3);
    chk(cal_done, 1'b1);
    wr_reg(`OFS_GLOBAL_CTRL, 32'h19);
    nx(1);
    chk(lk, 1'b1);
    wr_reg(`OFS_GLOBAL_CTRL, 32'h9);
    good <= 1'b1;
    nx(20);
    chk(lk, 1'b0);
    nx(60);
    chk(lk, 1'b1);
    @(posedge clk);
    loop_en <= 1'b1;
    good <= 1'b0;
    bad <= 1'b1;
    nx(30);
    chk(lk, 1'b0);
    watch(16);
    chk(hi, 8'h00);
    @(posedge clk);
    loop_en <= 1'b0;
    bad <= 1'b0;
    good <= 1'b1;
    cyc(80);
    wr_reg(`OFS_GLOBAL_CTRL, 32'h29);
    nx(4);
    chk(lk, 1'b0);
    wr_reg(`OFS_GLOBAL_CTRL, 32'h31);
    nx(4);
    chk(lk, 1'b1);
    print_verdict();
  end

  // Whole run needs about one thousand cycles
  initial begin
    repeat (6000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule : tb
